// >>> tw_regs.vh
// Purpose: Constants for the three-wire control block of the receiver front end
// Assumes: Bits shift in LSB first, address bits arrive last
// Notes:   Bit numbers below are global register bit numbers minus the register base
// Function
// RULE1: Flag multipath when field drop exceeds threshold; optionally mute audio.
// RULE2: Canceller control bit 0 enables muting on multipath; 1 disables it.
// RULE3: Canceller threshold 0000 off, 0001 low, 0011 -33, 0111 -14, 1111 -9 dB.
// RULE4: Canceller sensitivity acts only when band bit selects FM or weather band.
// RULE5: Multipath alert enable bit gates the alert onto the alert pin.
// RULE6: Alert pin selected by stop-enable and band bits, sources active low; with both bits set the code drives the pin low only for stop without alert.
// RULE7: AM noise blanker enabled by its enable bit.
// RULE8: Enabled blanker mutes second IF when noise peak exceeds sensitivity level.
// RULE9: Blanker sensitivity 000 low, 011 normal, 111 high, steps between.
// RULE10: Each command carries one whole register, updated as a whole.
// RULE11: Register chosen by command length (8 or 24) plus three address bits.
// RULE12: Host frames each command with frame select held high throughout.
// RULE13: Host sends LSB first; the three address bits arrive last.
// RULE14: Data sampled on serial clock rising edges while frame select high.
// RULE15: Rising clock edges counted per frame give the command length.
// RULE16: Bus shared with a synthesizer; only own length/address pairs accepted.
// RULE17: Five registers: 24-bit at 100,101,111; 8-bit at 100,101.
// RULE18: Host writes zeros to test-mode bits.
// RULE19: Composite audio mute bit set mutes the composite audio output.
// RULE20: Sensor reset bit ties multipath and adjacent detector nodes to ground.
// RULE21: Register applied only at frame end with matching length and address.
// RULE22: Bits collect in a shift register; active registers untouched meanwhile.
`ifndef TW_REGS_VH
`define TW_REGS_VH
`define TW_LEN_SHORT     5'd8
`define TW_LEN_LONG      5'd24
`define TW_ADDR_100      3'h4
`define TW_ADDR_101      3'h5
`define TW_ADDR_111      3'h7
`define TW_DATA_LONG_W   21
`define TW_DATA_SHORT_W  5
// Fields of the 24-bit register at 100 (base bit 73)
`define TW_SRCH_STOP_BIT 15
`define TW_BAND_BIT      19
`define TW_MNC_THR_LSB   8
`define TW_NB_SENS_LSB   12
// Fields of the 8-bit register at 100 (base bit 5)
`define TW_NB_EN_BIT     0
`define TW_SENS_RST_BIT  1
`define TW_AUD_MUTE_BIT  2
`define TW_MNC_DIS_BIT   3
// Field of the 8-bit register at 101 (base bit 0)
`define TW_MP_ALERT_BIT  4
// Reset values
`define TW_RST_LONG      21'h000000
`define TW_RST_SHORT     5'h00
`endif

// >>> tw_sync.v
// Purpose: Two-flop synchroniser for one pin
// Assumes: Input is asynchronous to clk_i
// Notes:   First stage feeds only the second
`default_nettype none
module tw_sync (
   // Clock and reset
   input  wire clk_i,
   input  wire rst_i,
   // Data
   input  wire d_i,
   output reg  q_o
);
   reg meta;
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta <= 1'b0;
         q_o  <= 1'b0;
      end else begin
         meta <= d_i;
         q_o  <= meta;
      end
   end
endmodule
`default_nettype wire

// >>> tw_control.v
// Purpose: Three-wire bus receiver and control register file with derived controls
// Assumes: Bus pins asynchronous, sampled at 40 MHz; serial clock much slower
// Notes:   Analog detector results arrive as pins and are synchronised here
`include "tw_regs.vh"
`default_nettype none
module tw_control (
   // Clock and reset
   input  wire        REF_CLK_I,
   input  wire        RST_I,
   // Three-wire bus
   input  wire        BUS_EN_I,
   input  wire        BUS_CLK_I,
   input  wire        BUS_DATA_I,
   // Detector results
   input  wire        FIELD_DROP_I,
   input  wire        SEARCH_STOP_I,
   input  wire        NOISE_PEAK_I,
   // Control outputs
   output reg         MULTIPATH_ALERT_O,
   output reg         ALERT_PIN_O,
   output reg         COMPOSITE_AUDIO_MUTE_O,
   output reg         SENSOR_RESET_O,
   output reg         BLANKER_EN_O,
   output reg         IF2_MUTE_O,
   output reg  [2:0]  BLANKER_LEVEL_O,
   output reg  [3:0]  MNC_THRESHOLD_O,
   output reg  [2:0]  MNC_SENS_O,
   output reg  [20:0] SEARCH_MP_CFG_O,
   output reg  [20:0] DEMOD_CFG_O,
   output reg  [20:0] OSC_CFG_O,
   output reg  [4:0]  ALERT_BW_CFG_O
);
   localparam MNC_OFF    = 3'd0;
   localparam MNC_LOW    = 3'd1;
   localparam MNC_M33    = 3'd2;
   localparam MNC_NORMAL = 3'd3;
   localparam MNC_HIGH   = 3'd4;

   wire        en_s;
   wire        sck_s;
   wire        sda_s;
   wire        drop_s;
   wire        stop_s;
   wire        peak_s;
   reg         en_d;
   reg         sck_d;
   reg  [23:0] shift;
   reg  [5:0]  count;
   reg  [20:0] reg_a100;
   reg  [20:0] reg_a101;
   reg  [20:0] reg_a111;
   reg  [4:0]  reg_b100;
   reg  [4:0]  reg_b101;
   reg         mp_flag;
   reg         alert_sel;
   reg  [2:0]  next_mnc_sens;

   tw_sync u_en   (.clk_i(REF_CLK_I), .rst_i(RST_I), .d_i(BUS_EN_I),      .q_o(en_s));
   tw_sync u_sck  (.clk_i(REF_CLK_I), .rst_i(RST_I), .d_i(BUS_CLK_I),     .q_o(sck_s));
   tw_sync u_sda  (.clk_i(REF_CLK_I), .rst_i(RST_I), .d_i(BUS_DATA_I),    .q_o(sda_s));
   tw_sync u_drop (.clk_i(REF_CLK_I), .rst_i(RST_I), .d_i(FIELD_DROP_I),  .q_o(drop_s));
   tw_sync u_stop (.clk_i(REF_CLK_I), .rst_i(RST_I), .d_i(SEARCH_STOP_I), .q_o(stop_s));
   tw_sync u_peak (.clk_i(REF_CLK_I), .rst_i(RST_I), .d_i(NOISE_PEAK_I),  .q_o(peak_s));

   wire sck_rise = sck_s & ~sck_d;
   wire en_rise  = en_s & ~en_d;
   wire en_fall  = ~en_s & en_d;
   // Address bits arrive last, so they sit at the top of whichever length was sent
   wire [2:0] addr_long  = shift[23:21];
   wire [2:0] addr_short = shift[23:21];

   // Serial receive; clock edges outside the frame are ignored
   always @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         en_d  <= 1'b0;
         sck_d <= 1'b0;
         shift <= 24'h000000;
         count <= 6'h00;
      end else begin
         en_d  <= en_s;
         sck_d <= sck_s;
         if (en_rise) begin
            count <= 6'h00;
         end else if (en_s && sck_rise) begin
            shift <= {sda_s, shift[23:1]}; // RULE14 RULE22
            if (count != 6'h3f) begin
               count <= count + 6'h01; // RULE15
            end
         end
      end
   end

   // Whole-register update at frame end only on own length and address
   always @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         reg_a100 <= `TW_RST_LONG;
         reg_a101 <= `TW_RST_LONG;
         reg_a111 <= `TW_RST_LONG;
         reg_b100 <= `TW_RST_SHORT;
         reg_b101 <= `TW_RST_SHORT;
      end else if (en_fall) begin // RULE21
         if (count == {1'b0, `TW_LEN_LONG}) begin // RULE11
            if (addr_long == `TW_ADDR_100) begin // RULE17
               reg_a100 <= shift[20:0]; // RULE10
            end else if (addr_long == `TW_ADDR_101) begin
               reg_a101 <= shift[20:0];
            end else if (addr_long == `TW_ADDR_111) begin
               reg_a111 <= shift[20:0];
            end
         end else if (count == {1'b0, `TW_LEN_SHORT}) begin
            // Unmatched pairs belong to the synthesizer on the same bus
            if (addr_short == `TW_ADDR_100) begin // RULE16
               reg_b100 <= shift[20:16];
            end else if (addr_short == `TW_ADDR_101) begin
               reg_b101 <= shift[20:16];
            end
         end
      end
   end

   // Threshold code decode; codes between named steps round down
   always @* begin
      next_mnc_sens = MNC_OFF;
      if (reg_a100[`TW_BAND_BIT]) begin // RULE4
         case (reg_a100[`TW_MNC_THR_LSB +: 4]) // RULE3
            4'h0:    next_mnc_sens = MNC_OFF;
            4'h1:    next_mnc_sens = MNC_LOW;
            4'h2:    next_mnc_sens = MNC_LOW;
            4'h3:    next_mnc_sens = MNC_M33;
            4'h7:    next_mnc_sens = MNC_NORMAL;
            4'hf:    next_mnc_sens = MNC_HIGH;
            default: next_mnc_sens = (reg_a100[`TW_MNC_THR_LSB + 3]) ? MNC_NORMAL : MNC_M33;
         endcase
      end
   end

   always @* begin
      // Multipath sensing is off when canceller is off or in AM
      mp_flag   = drop_s & (next_mnc_sens != MNC_OFF); // RULE1
      alert_sel = reg_b101[`TW_MP_ALERT_BIT] & mp_flag; // RULE5
   end

   always @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         MULTIPATH_ALERT_O      <= 1'b0;
         ALERT_PIN_O            <= 1'b1;
         COMPOSITE_AUDIO_MUTE_O <= 1'b0;
         SENSOR_RESET_O         <= 1'b0;
         BLANKER_EN_O           <= 1'b0;
         IF2_MUTE_O             <= 1'b0;
         BLANKER_LEVEL_O        <= 3'h0;
         MNC_THRESHOLD_O        <= 4'h0;
         MNC_SENS_O             <= 3'h0;
         SEARCH_MP_CFG_O        <= `TW_RST_LONG;
         DEMOD_CFG_O            <= `TW_RST_LONG;
         OSC_CFG_O              <= `TW_RST_LONG;
         ALERT_BW_CFG_O         <= `TW_RST_SHORT;
      end else begin
         MULTIPATH_ALERT_O <= mp_flag; // RULE1
         // Alert pin: stop treated as active high; alert active high alone, active low when paired with stop
         case ({reg_a100[`TW_SRCH_STOP_BIT], reg_a100[`TW_BAND_BIT]}) // RULE6
            2'b00:   ALERT_PIN_O <= 1'b1;
            2'b01:   ALERT_PIN_O <= ~alert_sel;
            2'b10:   ALERT_PIN_O <= ~stop_s;
            default: ALERT_PIN_O <= ~(stop_s & ~alert_sel);
         endcase
         COMPOSITE_AUDIO_MUTE_O <= reg_b100[`TW_AUD_MUTE_BIT] // RULE19
                                 | (~reg_b100[`TW_MNC_DIS_BIT] & mp_flag); // RULE2
         SENSOR_RESET_O  <= reg_b100[`TW_SENS_RST_BIT]; // RULE20
         BLANKER_EN_O    <= reg_b100[`TW_NB_EN_BIT]; // RULE7
         IF2_MUTE_O      <= reg_b100[`TW_NB_EN_BIT] & peak_s; // RULE8
         BLANKER_LEVEL_O <= reg_a100[`TW_NB_SENS_LSB +: 3]; // RULE9
         MNC_THRESHOLD_O <= reg_a100[`TW_MNC_THR_LSB +: 4];
         MNC_SENS_O      <= next_mnc_sens;
         SEARCH_MP_CFG_O <= reg_a100;
         DEMOD_CFG_O     <= reg_a101;
         OSC_CFG_O       <= reg_a111;
         ALERT_BW_CFG_O  <= reg_b101;
      end
   end
endmodule
`default_nettype wire

// >>> tw_control_assertions.sv
// Purpose: Port-level checks of the three-wire control block
// Assumes: Outputs settle a few cycles after a register update
// Notes:   Repetitions leave slack for the output pipeline
`default_nettype none
module tw_control_checker (
   // Clock and reset
   input wire logic        REF_CLK_I,
   input wire logic        RST_I,
   // Watched ports
   input wire logic        BUS_EN_I,
   input wire logic        MULTIPATH_ALERT_O,
   input wire logic        ALERT_PIN_O,
   input wire logic        BLANKER_EN_O,
   input wire logic        IF2_MUTE_O,
   input wire logic [2:0]  BLANKER_LEVEL_O,
   input wire logic [3:0]  MNC_THRESHOLD_O,
   input wire logic [2:0]  MNC_SENS_O,
   input wire logic [20:0] SEARCH_MP_CFG_O,
   input wire logic [4:0]  ALERT_BW_CFG_O
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [20:0] cfg;
   assign cfg = SEARCH_MP_CFG_O;
   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (RST_I);
   a_blank_gate: assert property (IF2_MUTE_O |-> BLANKER_EN_O || $past(BLANKER_EN_O))
      else $error("IF2 mute while blanker off");
   a_mp_needs_thr: assert property ($stable(cfg)[*4] ##0 MULTIPATH_ALERT_O |-> cfg[19] && cfg[11:8] != 4'h0)
      else $error("multipath flag without band or threshold");
   a_thr_field: assert property ($stable(cfg)[*3] |-> MNC_THRESHOLD_O == cfg[11:8])
      else $error("threshold field mismatch");
   a_blank_level: assert property ($stable(cfg)[*3] |-> BLANKER_LEVEL_O == cfg[14:12])
      else $error("blanker level mismatch");
   a_sens_am_off: assert property ($stable(cfg)[*3] ##0 !cfg[19] |-> MNC_SENS_O == 3'h0)
      else $error("canceller sensitivity active in AM");
   a_sens_high: assert property ((cfg[19] && cfg[11:8] == 4'hf)[*3] |-> MNC_SENS_O == 3'h4)
      else $error("high sensitivity not decoded");
   a_alert_quiet: assert property ((!cfg[15] && !ALERT_BW_CFG_O[4])[*4] |-> ALERT_PIN_O)
      else $error("alert pin active while sources gated");
   a_frame_hold: assert property (BUS_EN_I[*8] |-> $stable(cfg) && $stable(ALERT_BW_CFG_O))
      else $error("register changed within a frame");
endmodule
bind tw_control tw_control_checker u_chk (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I),
   .BUS_EN_I(BUS_EN_I), .MULTIPATH_ALERT_O(MULTIPATH_ALERT_O), .ALERT_PIN_O(ALERT_PIN_O),
   .BLANKER_EN_O(BLANKER_EN_O), .IF2_MUTE_O(IF2_MUTE_O), .BLANKER_LEVEL_O(BLANKER_LEVEL_O),
   .MNC_THRESHOLD_O(MNC_THRESHOLD_O), .MNC_SENS_O(MNC_SENS_O),
   .SEARCH_MP_CFG_O(SEARCH_MP_CFG_O), .ALERT_BW_CFG_O(ALERT_BW_CFG_O));
`default_nettype wire

// >>> tw_host_model.sv
// Purpose: Host end of the three-wire bus, one command per call
// Assumes: Serial clock period 300 ns, clock stands low between frames
// Notes:   Idle data line shows the inverse of its last bit
`default_nettype none
module tw_host_model (
   // Bus pins
   output var logic bus_en_o,
   output var logic bus_clk_o,
   output var logic bus_data_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      bus_en_o = 1'b0;
      bus_clk_o = 1'b0;
      bus_data_o = 1'b0;
   end
   task automatic send(input logic [20:0] d, input logic [2:0] a, input int n);
      logic [23:0] w;
      w = {a, d};
      if (n == 8) w[7:0] = {a, d[4:0]};
      bus_en_o = 1'b1;
      for (int i = 0; i < n; i++) begin
         #100 bus_data_o = w[i % 24];
         #100 bus_clk_o = 1'b1;
         #100 bus_clk_o = 1'b0;
      end
      #100 bus_en_o = 1'b0;
      bus_data_o = ~bus_data_o;
   endtask
endmodule
`default_nettype wire

// >>> tw_control_tb.sv
// Purpose: Self-checking bench for the three-wire control block
// Assumes: Results compared 10 cycles after each frame ends
// Notes:   Refused commands must leave every register image in the snapshot unchanged
`default_nettype none
module tw_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0, rst = 1'b1, drop = 1'b0, stop = 1'b0, peak = 1'b0;
   wire         en, sclk, sdata, mp, apin, amute, srst, blk, if2;
   wire  [2:0]  blvl, sens;
   wire  [3:0]  thr;
   wire  [20:0] smp, dem, osc;
   wire  [4:0]  abw;
   logic [20:0] e_smp = '0, e_dem = '0, e_osc = '0;
   logic [4:0]  e_s8 = '0, e_abw = '0;
   logic [83:0] q[$];
   logic [83:0] e;
   wire  [83:0] snap;
   logic [3:0]  codes[5] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hf};
   int          lens[4] = '{8, 24, 16, 25};
   int          fail_count = 0, n_compared = 0;
   always #12.5 clk = ~clk;
   tw_host_model u_host (.bus_en_o(en), .bus_clk_o(sclk), .bus_data_o(sdata));
   tw_control u_dut (.REF_CLK_I(clk), .RST_I(rst), .BUS_EN_I(en), .BUS_CLK_I(sclk),
      .BUS_DATA_I(sdata), .FIELD_DROP_I(drop), .SEARCH_STOP_I(stop), .NOISE_PEAK_I(peak),
      .MULTIPATH_ALERT_O(mp), .ALERT_PIN_O(apin), .COMPOSITE_AUDIO_MUTE_O(amute),
      .SENSOR_RESET_O(srst), .BLANKER_EN_O(blk), .IF2_MUTE_O(if2), .BLANKER_LEVEL_O(blvl),
      .MNC_THRESHOLD_O(thr), .MNC_SENS_O(sens), .SEARCH_MP_CFG_O(smp), .DEMOD_CFG_O(dem),
      .OSC_CFG_O(osc), .ALERT_BW_CFG_O(abw));
   function automatic logic [2:0] sens_of(input logic [20:0] s);
      if (!s[19]) return 3'h0;
      case (s[11:8])
         4'h0: return 3'h0;
         4'h1, 4'h2: return 3'h1;
         4'h3: return 3'h2;
         4'h7: return 3'h3;
         4'hf: return 3'h4;
         default: return s[11] ? 3'h3 : 3'h2;
      endcase
   endfunction
   function automatic logic [83:0] exp_vec();
      logic m;
      logic a;
      logic p;
      m = drop & e_smp[19] & (e_smp[11:8] != 4'h0);
      a = e_abw[4] & m;
      // Pin table taken with stop active high; alert active high alone, active low when paired with stop
      case ({e_smp[15], e_smp[19]})
         2'b00:   p = 1'b1;
         2'b01:   p = ~a;
         2'b10:   p = ~stop;
         default: p = ~(stop & ~a);
      endcase
      return {e_smp, e_dem, e_osc, e_abw, sens_of(e_smp), e_s8[0], e_s8[1], e_s8[0] & peak,
              m, e_s8[2] | (~e_s8[3] & m), p, e_smp[14:12], e_smp[11:8]};
   endfunction
   task automatic chk(input logic [83:0] seen, input logic [83:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("FAIL %0t snapshot %h expected %h", $time, seen, exp);
      end
   endtask
   assign snap = {smp, dem, osc, abw, sens, blk, srst, if2, mp, amute, apin, blvl, thr};
   always @(negedge clk) begin
      if (q.size() != 0) begin
         e = q.pop_front();
         chk(84'(snap[83:16]), 84'(e[83:16]));
         chk(84'(snap[15:13]), 84'(e[15:13]));
         chk(84'(snap[12:0]), 84'(e[12:0]));
      end
   end
   task automatic wr(input logic [20:0] d, input logic [2:0] a, input int n);
      @(negedge clk);
      {drop, stop, peak} = 3'($urandom);
      if (n == 24 && a == 3'h7) d[19:12] = '0;
      if (n == 8 && a == 3'h4) d[4] = 1'b0;
      u_host.send(d, a, n);
      case ({n == 24, n == 8, a})
         5'h14: e_smp = d;
         5'h15: e_dem = d;
         5'h17: e_osc = d;
         5'h0c: e_s8 = d[4:0];
         5'h0d: e_abw = d[4:0];
         default: ;
      endcase
      repeat (10) @(negedge clk);
      q.push_back(exp_vec());
      repeat (2) @(negedge clk);
   endtask
   task automatic end_of_test;
      if (fail_count == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      void'($urandom(78041));
      repeat (16) @(negedge clk);
      rst = 1'b0;
      repeat (3) @(negedge clk);
      q.push_back(exp_vec());
      foreach (codes[i]) wr((21'($urandom) & ~21'h080f00) | 21'h080000 | {9'h0, codes[i], 8'h0}, 3'h4, 24);
      for (int i = 0; i < 40; i++) begin
         wr(21'($urandom), (i < 16) ? 3'(i) : 3'($urandom), (i < 8) ? 8 : (i < 16) ? 24 : lens[$urandom % 4]);
      end
      repeat (20) @(negedge clk);
      end_of_test();
   end
   initial begin
      #1ms;
      fail_count++;
      end_of_test();
   end
endmodule
`default_nettype wire
